/* rtl/lsd_defs.svh */
// How it works
// [R01] In normal mode a high strobe line makes the output latch transparent so each sink follows its shifted bit.
// [R02] In normal mode a low strobe line freezes the output latch while shifting goes on.
// [R03] A high enable line turns every sink off at once, and shifting carries on meanwhile.
// [R04] While a mode switch is pending the strobe line only picks the next mode and copies no data.
// [R05] In special mode a strobe pulse copies the shift register into the 8-bit configuration latch.
// [R06] In special mode the captured error bits can be clocked out on the cascade serial output.
// [R07] The controller holds the enable line low for at least 2000 ns so that valid error bits are built.
// [R08] One configuration bit selects the current multiplier, and clearing it lowers the usable current range.
// [R09] A low pulse one serial clock wide on the enable line starts the mode switching phase.
// [R10] In the switching phase the strobe level picks special mode when high and normal mode when low.
// [R11] In special mode a low enable line drives the sinks, checks the loads and loads the error bits.
// [R12] An 8-stage shift register advances from serial input to cascade output on each rising serial clock edge that does not load error bits.
`ifndef LSD_DEFS_SVH
`define LSD_DEFS_SVH

`define LSD_CH_N         8
`define LSD_FIFO_DEPTH   16
`define LSD_CM_BIT       7
`define LSD_SHIFT_RST    8'h00
`define LSD_LATCH_RST    8'h00
`define LSD_CFG_RST      8'hff
`define LSD_HIST_RST     2'h3
`define LSD_CLK_MHZ      200
`define LSD_DET_TIME_NS  2000
`define LSD_DET_CYC      ((`LSD_DET_TIME_NS * `LSD_CLK_MHZ + 999) / 1000)
`define LSD_DET_CNT_W    10

`endif

/* rtl/lsd_pkg.sv */
`default_nettype none
`include "lsd_defs.svh"

package lsd_pkg;

  typedef enum logic [1:0] {
    LSD_ST_NORMAL  = 2'b00,
    LSD_ST_SWITCH  = 2'b01,
    LSD_ST_SPECIAL = 2'b10
  } lsd_state_t;

  typedef struct packed {
    logic                     is_cfg;
    logic [`LSD_CH_N-1:0]     data;
  } lsd_word_t;

  typedef struct packed {
    logic [`LSD_CH_N-1:0]     err;
    logic                     sclk;
    logic                     serial_in;
    logic                     stb;
    logic                     en;
  } lsd_pins_t;

endpackage

`default_nettype wire

/* rtl/lsd_fifo.sv */
`timescale 1ns/100ps
`default_nettype none

module lsd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    wr_d;
  logic [AW-1:0]    rd_q;
  logic [AW-1:0]    rd_d;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  // Full and empty come straight from the fill count.
  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    wr_d  = push ? ((wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d  = pop ? ((rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset; only written slots are ever read.
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

endmodule // lsd_fifo

`default_nettype wire

/* rtl/lsd_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lsd_defs.svh"

module lsd_top #(
  parameter int CH_N       = `LSD_CH_N,
  parameter int FIFO_DEPTH = `LSD_FIFO_DEPTH
) (
  input  wire logic            sys_clk_i,
  input  wire logic            rst_b_i,
  input  wire logic            sclk_i,
  input  wire logic            serial_in_i,
  input  wire logic            strobe_mode_select_i,
  input  wire logic            enable_switch_detect_i,
  input  wire logic [CH_N-1:0] led_error_i,
  input  wire logic            sink_hold_i,
  output logic      [CH_N-1:0] channel_sinks_o,
  output logic                 cascade_serial_out_o,
  output logic      [CH_N-1:0] config_o,
  output logic                 current_multiplier_bit_o,
  output logic                 special_mode_o,
  output logic                 capture_ready_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  lsd_pkg::lsd_pins_t raw;
  lsd_pkg::lsd_pins_t s1_q;
  lsd_pkg::lsd_pins_t s2_q;
  lsd_pkg::lsd_pins_t prev_q;
  lsd_pkg::lsd_pins_t s1_d;
  lsd_pkg::lsd_pins_t s2_d;
  lsd_pkg::lsd_pins_t prev_d;

  logic            sclk_rise;
  logic            stb_rise;
  logic            en_s;
  logic            stb_s;
  logic            sdi_s;
  logic [CH_N-1:0] err_s;

  assign raw.err  = led_error_i;
  assign raw.sclk = sclk_i;
  assign raw.serial_in  = serial_in_i;
  assign raw.stb  = strobe_mode_select_i;
  assign raw.en   = enable_switch_detect_i;

  always_comb begin
    s1_d   = raw;
    s2_d   = s1_q;
    prev_d = s2_q;
  end

  // The enable line idles high so the sinks start blanked.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_q   <= '{err: '0, sclk: 1'b0, serial_in: 1'b0, stb: 1'b0, en: 1'b1};
      s2_q   <= '{err: '0, sclk: 1'b0, serial_in: 1'b0, stb: 1'b0, en: 1'b1};
      prev_q <= '{err: '0, sclk: 1'b0, serial_in: 1'b0, stb: 1'b0, en: 1'b1};
    end else begin
      s1_q   <= s1_d;
      s2_q   <= s2_d;
      prev_q <= prev_d;
    end
  end

  assign sclk_rise = s2_q.sclk & ~prev_q.sclk;
  assign stb_rise  = s2_q.stb & ~prev_q.stb;
  assign en_s      = s2_q.en;
  assign stb_s     = s2_q.stb;
  assign sdi_s     = s2_q.serial_in;
  assign err_s     = s2_q.err;

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencing.

  lsd_pkg::lsd_state_t state_q;
  lsd_pkg::lsd_state_t state_d;
  logic [1:0]          hist_q;
  logic [1:0]          hist_d;
  logic                sw_pulse;

  // The enable line was high, then low for one serial clock, now high again.
  assign sw_pulse = hist_q[1] & ~hist_q[0] & en_s; // [R09]

  always_comb begin
    state_d = state_q;
    hist_d  = hist_q;
    if (sclk_rise) begin
      hist_d = {hist_q[0], en_s};
      case (state_q)
        lsd_pkg::LSD_ST_NORMAL,
        lsd_pkg::LSD_ST_SPECIAL: begin
          if (sw_pulse) begin
            state_d = lsd_pkg::LSD_ST_SWITCH; // [R09]
          end
        end
        lsd_pkg::LSD_ST_SWITCH: begin
          state_d = stb_s ? lsd_pkg::LSD_ST_SPECIAL : lsd_pkg::LSD_ST_NORMAL; // [R10]
        end
        default: begin
          state_d = lsd_pkg::LSD_ST_NORMAL;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= lsd_pkg::LSD_ST_NORMAL;
      hist_q  <= `LSD_HIST_RST;
    end else begin
      state_q <= state_d;
      hist_q  <= hist_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error detection timer and shift register.

  localparam logic [`LSD_DET_CNT_W-1:0] DET_CYC = `LSD_DET_CNT_W'(`LSD_DET_CYC);

  logic [`LSD_DET_CNT_W-1:0] det_cnt_q;
  logic [`LSD_DET_CNT_W-1:0] det_cnt_d;
  logic                      detecting;
  logic                      det_done;
  logic                      load_err;
  logic [CH_N-1:0]           shift_q;
  logic [CH_N-1:0]           shift_d;

  assign detecting = (state_q == lsd_pkg::LSD_ST_SPECIAL) & ~en_s; // [R11]
  assign det_done  = (det_cnt_q == DET_CYC);
  assign load_err  = sclk_rise & detecting & det_done; // [R11]

  always_comb begin
    det_cnt_d = '0;
    if (detecting) begin
      det_cnt_d = det_done ? det_cnt_q : det_cnt_q + 1'b1;
    end
    shift_d = shift_q;
    if (load_err) begin
      shift_d = err_s; // [R06] [R11]
    end else if (sclk_rise) begin
      shift_d = {shift_q[CH_N-2:0], sdi_s}; // [R12]
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      det_cnt_q <= '0;
      shift_q   <= `LSD_SHIFT_RST;
    end else begin
      det_cnt_q <= det_cnt_d;
      shift_q   <= shift_d;
    end
  end

  assign cascade_serial_out_o = shift_q[CH_N-1]; // [R06] [R12]

  ////////////////////////////////////////////////////////////////////////////
  // Capture of latch updates into the FIFO.

  lsd_pkg::lsd_word_t push_w;
  lsd_pkg::lsd_word_t pop_w;
  logic               push_v;
  logic               pop_v;
  logic               pop_rdy;
  logic               fifo_rdy;

  always_comb begin
    push_v = 1'b0;
    push_w = '{is_cfg: 1'b0, data: shift_d};
    case (state_q)
      lsd_pkg::LSD_ST_NORMAL: begin
        push_v = stb_s & (stb_rise | sclk_rise); // [R01] [R02]
      end
      lsd_pkg::LSD_ST_SPECIAL: begin
        push_v = stb_rise; // [R05]
        push_w = '{is_cfg: 1'b1, data: shift_q};
      end
      default: begin
        push_v = 1'b0; // [R04]
      end
    endcase
  end

  lsd_fifo #(
    .WIDTH ($bits(lsd_pkg::lsd_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (push_v),
    .in_ready_o  (fifo_rdy),
    .in_data_i   (push_w),
    .out_valid_o (pop_v),
    .out_ready_i (pop_rdy),
    .out_data_o  (pop_w)
  );

  assign pop_rdy         = ~sink_hold_i;
  assign capture_ready_o = fifo_rdy;

  ////////////////////////////////////////////////////////////////////////////
  // Output latch, configuration latch and sinks.

  logic [CH_N-1:0] out_latch_q;
  logic [CH_N-1:0] out_latch_d;
  logic [CH_N-1:0] cfg_q;
  logic [CH_N-1:0] cfg_d;
  logic [CH_N-1:0] sinks_q;
  logic [CH_N-1:0] sinks_d;
  logic            pop;

  assign pop = pop_v & pop_rdy;

  always_comb begin
    out_latch_d = out_latch_q;
    cfg_d       = cfg_q;
    if (pop && pop_w.is_cfg) begin
      cfg_d = pop_w.data; // [R05]
    end else if (pop) begin
      out_latch_d = pop_w.data; // [R01]
    end
    sinks_d = en_s ? '0 : out_latch_q; // [R03] [R11]
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_latch_q <= `LSD_LATCH_RST;
      cfg_q       <= `LSD_CFG_RST;
      sinks_q     <= '0;
    end else begin
      out_latch_q <= out_latch_d;
      cfg_q       <= cfg_d;
      sinks_q     <= sinks_d;
    end
  end

  assign channel_sinks_o          = sinks_q;
  assign config_o                 = cfg_q;
  assign current_multiplier_bit_o = cfg_q[`LSD_CM_BIT]; // [R08]
  assign special_mode_o           = (state_q == lsd_pkg::LSD_ST_SPECIAL);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sinks_blank_a: assert property (en_s |=> channel_sinks_o == '0) // [R03]
    else $error("sinks not blanked while enable line high");

  sinks_follow_a: assert property (!en_s |=> channel_sinks_o == $past(out_latch_q)) // [R01]
    else $error("sinks do not follow output latch");

  latch_hold_a: assert property ((state_q == lsd_pkg::LSD_ST_NORMAL && !stb_s) |-> !push_v) // [R02]
    else $error("latch update captured while strobe low");

  switch_nolatch_a: assert property (state_q == lsd_pkg::LSD_ST_SWITCH |-> !push_v) // [R04]
    else $error("data captured during mode switching");

  cfg_load_a: assert property ((pop && pop_w.is_cfg) |=> (config_o == $past(pop_w.data)
                                && current_multiplier_bit_o == $past(pop_w.data[`LSD_CM_BIT]))) // [R05]
    else $error("configuration latch not loaded");

  cm_select_a: assert property (!(pop && pop_w.is_cfg) |=> $stable(current_multiplier_bit_o)) // [R08]
    else $error("current multiplier bit changed without a configuration load");

  err_load_a: assert property (load_err |=> shift_q == $past(err_s) ##0
                               cascade_serial_out_o == $past(err_s[CH_N-1])) // [R06]
    else $error("error bits not loaded into shift register");

  err_guard_a: assert property ((sclk_rise && detecting && !det_done) |=> shift_q[0] == $past(sdi_s)) // [R11]
    else $error("error bits loaded before detection time");

  shift_step_a: assert property ((sclk_rise && !load_err) |=>
                                 shift_q == {$past(shift_q[CH_N-2:0]), $past(sdi_s)}) // [R12]
    else $error("shift register did not advance");

  mode_enter_a: assert property ((sclk_rise && sw_pulse && state_q != lsd_pkg::LSD_ST_SWITCH)
                                 |=> state_q == lsd_pkg::LSD_ST_SWITCH) // [R09]
    else $error("mode switch pulse not honoured");

  mode_pick_a: assert property ((sclk_rise && state_q == lsd_pkg::LSD_ST_SWITCH) |=>
                                state_q == ($past(stb_s) ? lsd_pkg::LSD_ST_SPECIAL : lsd_pkg::LSD_ST_NORMAL)) // [R10]
    else $error("wrong next mode chosen");

endmodule // lsd_top

`default_nettype wire

/* sim/lsd_ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none

module lsd_ctrl_model (
  input  wire logic clk_i,
  output logic      sclk_o,
  output logic      sdi_o,
  output logic      stb_o,
  output logic      en_o
);
  initial begin
    sclk_o = 1'b0;
    sdi_o  = 1'b0;
    stb_o  = 1'b0;
    en_o   = 1'b1;
  end

  ////////////////////////////////////////////////////////////
  // Drives one serial bit with strobe and enable held across the clock rise.
  task automatic clk_bit(input logic d, input logic s, input logic e);
    @(posedge clk_i);
    sdi_o <= d;
    stb_o <= s;
    en_o  <= e;
    repeat (5) @(posedge clk_i);
    sclk_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    sclk_o <= 1'b0;
    sdi_o  <= ~d;
  endtask

  task automatic send_byte(input logic [7:0] v, input logic s, input logic e);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(v[i], s, e);
    end
  endtask

  task automatic set_lines(input logic s, input logic e);
    @(posedge clk_i);
    stb_o <= s;
    en_o  <= e;
  endtask

  task automatic strobe_pulse();
    @(posedge clk_i);
    stb_o <= 1'b1;
    repeat (10) @(posedge clk_i);
    stb_o <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask

  // Sends a one clock wide low pulse on the enable line, then the mode level.
  task automatic switch_mode(input logic s);
    clk_bit(1'b0, 1'b0, 1'b1);
    clk_bit(1'b0, 1'b0, 1'b0);
    clk_bit(1'b0, 1'b0, 1'b1);
    clk_bit(1'b0, s, 1'b1);
    set_lines(1'b0, 1'b1);
  endtask

  // Holds the enable line low past the detection time, then clocks twice while low.
  task automatic detect();
    set_lines(1'b0, 1'b0);
    repeat (430) @(posedge clk_i);
    clk_bit(1'b0, 1'b0, 1'b0);
    clk_bit(1'b0, 1'b0, 1'b0);
  endtask
endmodule // lsd_ctrl_model

`default_nettype wire

/* sim/lsd_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module lsd_tb_top;
  logic       sys_clk;
  logic       rst_b;
  logic       sclk;
  logic       serial_in;
  logic       stb;
  logic       en;
  logic       hold;
  logic [7:0] led_err;
  logic [7:0] sinks;
  logic [7:0] cfg;
  logic       cascade_serial_out;
  logic       cm;
  logic       spec;
  logic       rdy;
  int         errors = 0;
  int         tests_run = 0;
  int         cycles = 0;

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  lsd_top dut (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b), .sclk_i(sclk), .serial_in_i(serial_in),
    .strobe_mode_select_i(stb), .enable_switch_detect_i(en), .led_error_i(led_err),
    .sink_hold_i(hold), .channel_sinks_o(sinks), .cascade_serial_out_o(cascade_serial_out), .config_o(cfg),
    .current_multiplier_bit_o(cm), .special_mode_o(spec), .capture_ready_o(rdy)
  );

  lsd_ctrl_model ctrl (.clk_i(sys_clk), .sclk_o(sclk), .sdi_o(serial_in), .stb_o(stb), .en_o(en));

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_normal();
    ctrl.send_byte(8'ha5, 1'b0, 1'b0);
    wait_cyc(10);
    check(sinks, 8'h00);
    check({7'h0, cascade_serial_out}, 8'h01);
    ctrl.strobe_pulse();
    check(sinks, 8'ha5);
    ctrl.send_byte(8'h3c, 1'b0, 1'b0);
    wait_cyc(10);
    check(sinks, 8'ha5);
    $display("test normal done");
  endtask

  task automatic t_blank();
    ctrl.set_lines(1'b0, 1'b1);
    wait_cyc(10);
    check(sinks, 8'h00);
    ctrl.send_byte(8'hc3, 1'b0, 1'b1);
    wait_cyc(10);
    check({7'h0, cascade_serial_out}, 8'h01);
    ctrl.set_lines(1'b0, 1'b0);
    wait_cyc(10);
    check(sinks, 8'ha5);
    $display("test blank done");
  endtask

  task automatic t_config();
    check(cfg, 8'hff);
    ctrl.switch_mode(1'b1);
    wait_cyc(10);
    check({7'h0, spec}, 8'h01);
    check(cfg, 8'hff);
    ctrl.send_byte(8'h4b, 1'b0, 1'b1);
    ctrl.strobe_pulse();
    check(cfg, 8'h4b);
    check({7'h0, cm}, 8'h00);
    ctrl.send_byte(8'hc3, 1'b0, 1'b1);
    ctrl.strobe_pulse();
    check({7'h0, cm}, 8'h01);
    ctrl.set_lines(1'b0, 1'b0);
    wait_cyc(10);
    check(sinks, 8'ha5);
    $display("test config done");
  endtask

  task automatic t_errors();
    @(posedge sys_clk);
    led_err <= 8'h96;
    ctrl.detect();
    wait_cyc(10);
    check(sinks, 8'ha5);
    ctrl.set_lines(1'b0, 1'b1);
    wait_cyc(10);
    for (int i = 7; i >= 0; i--) begin
      check({7'h0, cascade_serial_out}, {7'h0, led_err[i]});
      ctrl.clk_bit(1'b0, 1'b0, 1'b1);
      wait_cyc(4);
    end
    ctrl.switch_mode(1'b0);
    wait_cyc(10);
    check({7'h0, spec}, 8'h00);
    $display("test errors done");
  endtask

  task automatic t_fifo();
    @(posedge sys_clk);
    hold <= 1'b1;
    ctrl.set_lines(1'b1, 1'b0);
    for (int i = 0; i < 20; i++) begin
      ctrl.clk_bit(i[0], 1'b1, 1'b0);
    end
    wait_cyc(10);
    check({7'h0, rdy}, 8'h00);
    check(sinks, 8'ha5);
    hold <= 1'b0;
    wait_cyc(40);
    check({7'h0, rdy}, 8'h01);
    ctrl.send_byte(8'h69, 1'b1, 1'b0);
    wait_cyc(12);
    check(sinks, 8'h69);
    ctrl.set_lines(1'b0, 1'b0);
    $display("test fifo done");
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      conclude();
    end
  end

  initial begin
    rst_b   = 1'b0;
    hold    = 1'b0;
    led_err = 8'h00;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    wait_cyc(4);
    t_normal();
    t_blank();
    t_config();
    t_errors();
    t_fifo();
    conclude();
  end
endmodule // lsd_tb_top

`default_nettype wire
